// ---- src/aarr_top.sv ----
// aarr_top: auxiliary converter result registers and converter run/stop bit,
// reached by the host through the 16-bit command word serial port
// assumes SPI mode 0 (sample on rising SCLK, drive on falling), SCLK well
// below CLK/8, and a converter core on CLK giving start/done pulses
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1: reset clears all result registers to zero
// RULE2: result registers are read only to host
// RULE3: store result in the measured channel's register
// RULE4: twelve bits right-justified, top nibble zero
// RULE5: control bits decoded separately for read, write
// RULE6: host writes zero to reserved top bit
// RULE7: status bit reads zero busy, one idle
// RULE8: writing one aborts and powers down converter
// RULE9: writing zero selects normal converter operation
// RULE10: command word: direction, page, index, zero pad
// RULE11: read auto-increments; past page end gives ones
// RULE12: busy holds from start until result stored
module aarr_top (
  // clock, reset, enable
  input  wire logic                        CLK,
  input  wire logic                        SYS_RST,
  input  wire logic                        CE,
  // serial host port
  input  wire logic                        SPI_SCLK,
  input  wire logic                        SPI_CS_N,
  input  wire logic                        SPI_MOSI,
  output logic                             SPI_MISO,
  output logic                             SPI_MISO_OE,
  // converter core
  input  wire logic                        CONV_START,
  input  wire logic                        CONV_DONE,
  input  wire logic [2:0]                  CONV_CHAN,
  input  wire logic [aarr_pkg::RES_W-1:0]  CONV_DATA,
  output logic                             CONV_BUSY,
  output logic                             CONV_ABORT,
  output logic                             CONV_POWER_DOWN
);
  import aarr_pkg::*;

  // ==========================================================================
  // declarations
  logic              sclk_f;
  logic              cs_n_f;
  logic              mosi_f;
  logic              sclk_p;
  logic              rise;
  logic              fall;
  logic [3:0]        bit_cnt;
  logic [15:0]       rx;
  logic [15:0]       next_rx;
  logic              word_done;
  aarr_state_t       state;
  logic [3:0]        page;
  logic [5:0]        ptr;
  logic              past_end;
  logic              load_pending;
  logic [15:0]       tx;
  logic [15:0]       rd_word;
  logic              wr_ctrl;
  logic              cmd_ok;
  logic              busy;
  logic              pd;
  logic [RES_W-1:0]  res [CH_NUM];

  // ==========================================================================
  // pin synchronisers; CS idles high so it resets to one
  aarr_pin_sync #(.W(3), .RST_VAL(16'h0002)) u_sync (
    .clk   (CLK),
    .rst   (SYS_RST),
    .ce    (CE),
    .pin   ({SPI_SCLK, SPI_CS_N, SPI_MOSI}),
    .level ({sclk_f, cs_n_f, mosi_f})
  );

  // edge history of the filtered clock
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sclk_p <= 1'b0;
    end else if (CE) begin
      sclk_p <= sclk_f;
    end
  end

  // edges count only inside a selected frame
  assign rise      = CE && !cs_n_f && sclk_f && !sclk_p;
  assign fall      = CE && !cs_n_f && !sclk_f && sclk_p;
  assign next_rx   = {rx[14:0], mosi_f};
  assign word_done = rise && (bit_cnt == BIT_LAST);
  assign cmd_ok    = (next_rx[CMD_PAD_MSB:0] == 5'h00);

  // ==========================================================================
  // bit counter and receive shifter; deselect realigns the word boundary
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      bit_cnt <= 4'h0;
      rx      <= 16'h0000;
    end else if (CE) begin
      if (cs_n_f) begin
        bit_cnt <= 4'h0;
      end else if (rise) begin
        bit_cnt <= bit_cnt + 4'h1;
        rx      <= next_rx;
      end
    end
  end

  // ==========================================================================
  // frame engine: command word, then a run of data words
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state    <= ST_IDLE;
      page     <= PAGE_DATA;
      ptr      <= IDX_CONV_CTRL;
      past_end <= 1'b0;
    end else if (CE) begin
      if (cs_n_f) begin
        state <= ST_IDLE;
      end else begin
        case (state)
          ST_IDLE: begin
            state <= ST_CMD;
          end
          ST_CMD: begin
            if (word_done) begin
              // a command with a nonzero pad is not trusted; rest of frame ignored
              if (!cmd_ok) begin // see RULE10
                state <= ST_SKIP;
              end else if (next_rx[CMD_DIR_BIT]) begin
                state <= ST_READ;
              end else begin
                state <= ST_WRITE;
              end
              page     <= next_rx[CMD_PAGE_MSB:CMD_PAGE_LSB]; // see RULE10
              ptr      <= next_rx[CMD_IDX_MSB:CMD_IDX_LSB];
              past_end <= 1'b0;
            end
          end
          ST_READ, ST_WRITE: begin
            // pointer stops at page end; later words see the past-end flag
            if (word_done) begin
              if (ptr == IDX_LAST) begin // see RULE11
                past_end <= 1'b1;
              end else begin
                ptr <= ptr + 6'h01;
              end
            end
          end
          ST_SKIP: begin
            state <= ST_SKIP;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // read decode: the status bit reads busy state, not the written value
  always_comb begin
    rd_word = RSVD_WORD;
    if (past_end) begin
      rd_word = PAST_END_WORD; // see RULE11
    end else if (page == PAGE_DATA) begin
      case (ptr) // see RULE4
        IDX_BATTERY:  rd_word = {4'h0, res[CH_BATTERY]};
        IDX_AUX_ONE:  rd_word = {4'h0, res[CH_AUX_ONE]};
        IDX_AUX_TWO:  rd_word = {4'h0, res[CH_AUX_TWO]};
        IDX_TEMP_ONE: rd_word = {4'h0, res[CH_TEMP_ONE]};
        IDX_TEMP_TWO: rd_word = {4'h0, res[CH_TEMP_TWO]};
        default:      rd_word = RSVD_WORD;
      endcase
    end else if ((page == PAGE_AUXCTL) && (ptr == IDX_CONV_CTRL)) begin
      rd_word[CTRL_RSVD_BIT] = 1'b0;  // see RULE6
      rd_word[CTRL_STOP_BIT] = !busy; // see RULE5 see RULE7
    end
  end

  // ==========================================================================
  // transmit shifter; the next word is fetched at the first falling edge
  // so the pointer has already advanced past the finished word
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tx           <= 16'h0000;
      load_pending <= 1'b0;
      SPI_MISO     <= 1'b0;
      SPI_MISO_OE  <= 1'b0;
    end else if (CE) begin
      if (cs_n_f) begin
        tx           <= 16'h0000; // stale bits must not leak into the next command word
        load_pending <= 1'b0;
        SPI_MISO     <= 1'b0;
        SPI_MISO_OE  <= 1'b0;
      end else begin
        if (word_done && cmd_ok && (state == ST_CMD) && next_rx[CMD_DIR_BIT]) begin
          load_pending <= 1'b1;
        end else if (word_done && (state == ST_READ)) begin
          load_pending <= 1'b1; // see RULE11
        end else if (fall && load_pending) begin
          load_pending <= 1'b0;
        end
        if (fall) begin
          SPI_MISO_OE <= (state == ST_READ);
          if (load_pending) begin
            tx       <= {rd_word[14:0], 1'b0};
            SPI_MISO <= rd_word[15];
          end else begin
            tx       <= {tx[14:0], 1'b0};
            SPI_MISO <= tx[15];
          end
        end
      end
    end
  end

  // ==========================================================================
  // write decode: only the run/stop bit of the control word is writable
  assign wr_ctrl = word_done && (state == ST_WRITE) && !past_end
                   && (page == PAGE_AUXCTL) && (ptr == IDX_CONV_CTRL);

  // converter run state; abort wins over done, done then start re-arms
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      busy <= 1'b0;
      pd   <= 1'b0; // see RULE9
    end else if (CE) begin
      if (wr_ctrl) begin
        pd <= next_rx[CTRL_STOP_BIT]; // see RULE5 see RULE9
      end
      if (wr_ctrl && next_rx[CTRL_STOP_BIT]) begin
        busy <= 1'b0; // see RULE8
      end else begin
        if (CONV_DONE) begin
          busy <= 1'b0; // see RULE12
        end
        if (CONV_START && !pd) begin
          busy <= 1'b1; // see RULE12
        end
      end
    end
  end

  // abort is a one-cycle request to the converter core
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      CONV_ABORT <= 1'b0;
    end else if (CE) begin
      CONV_ABORT <= wr_ctrl && next_rx[CTRL_STOP_BIT]; // see RULE8
    end
  end

  // ==========================================================================
  // result store; a done after an abort is dropped since busy is clear
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < CH_NUM; i++) begin
        res[i] <= RESULT_RST[RES_W-1:0]; // see RULE1
      end
    end else if (CE && CONV_DONE && busy) begin
      // the host path has no write port here, so results stay read only
      for (int i = 0; i < CH_NUM; i++) begin
        if (CONV_CHAN == 3'(i)) begin
          res[i] <= CONV_DATA; // see RULE2 see RULE3
        end
      end
    end
  end

  assign CONV_BUSY       = busy;
  assign CONV_POWER_DOWN = pd;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_start;
    CE && CONV_START && !pd && !wr_ctrl;
  endsequence

  sequence s_hold;
    busy && !CONV_DONE && !wr_ctrl && CE;
  endsequence

  sequence s_stop_write;
    wr_ctrl && next_rx[CTRL_STOP_BIT];
  endsequence

  a_busy_start: assert property (s_start |=> busy) // see RULE12
    else $error("busy not raised by a start");

  a_busy_hold: assert property (s_hold |=> busy) // see RULE12
    else $error("busy dropped before result stored");

  a_stop_abort: assert property (s_stop_write |=> CONV_ABORT && !busy && pd ##1 !CONV_ABORT) // see RULE8
    else $error("stop write did not abort and power down");

  a_normal_write: assert property (wr_ctrl && !next_rx[CTRL_STOP_BIT] |=> !pd) // see RULE9
    else $error("zero write did not select normal mode");

  a_status_read: assert property ((page == PAGE_AUXCTL) && (ptr == IDX_CONV_CTRL) && !past_end
                                  |-> rd_word == {1'b0, !busy, 14'h0000}) // see RULE7
    else $error("status bit does not reflect busy");

  a_result_just: assert property ((page == PAGE_DATA) |-> rd_word[15:12] == 4'h0 || past_end) // see RULE4
    else $error("result word upper bits not zero");

  a_temp_store: assert property (CE && CONV_DONE && busy && (CONV_CHAN == CH_TEMP_ONE)
                                 |=> res[CH_TEMP_ONE] == $past(CONV_DATA)) // see RULE3
    else $error("temperature result not stored");

  a_result_kept: assert property (!(CE && CONV_DONE && busy)
                                  |=> $stable({res[0], res[1], res[2], res[3], res[4]})) // see RULE2
    else $error("result changed without a conversion");

  a_past_end: assert property (past_end |-> rd_word == PAST_END_WORD) // see RULE11
    else $error("past page end did not read all ones");

  a_bad_pad: assert property (word_done && (state == ST_CMD) && !cmd_ok
                              |=> state == ST_SKIP || state == ST_IDLE) // see RULE10
    else $error("command with nonzero pad accepted");

endmodule
`default_nettype wire

// ---- src/aarr_pkg.sv ----
// aarr_pkg: constants shared by the auxiliary converter result register block
// assumes a 16-bit command word serial host port and a 12-bit converter core
package aarr_pkg;

  // ==========================================================================
  // command word layout
  localparam int          CMD_W        = 16;
  localparam int          CMD_DIR_BIT  = 15;
  localparam int          CMD_PAGE_MSB = 14;
  localparam int          CMD_PAGE_LSB = 11;
  localparam int          CMD_IDX_MSB  = 10;
  localparam int          CMD_IDX_LSB  = 5;
  localparam int          CMD_PAD_MSB  = 4;
  localparam logic [3:0]  BIT_LAST     = 4'hF;

  // ==========================================================================
  // page and register index map
  localparam logic [3:0]  PAGE_DATA    = 4'h0;
  localparam logic [3:0]  PAGE_AUXCTL  = 4'h1;
  localparam logic [5:0]  IDX_CONV_CTRL = 6'h00;
  localparam logic [5:0]  IDX_BATTERY  = 6'h05;
  localparam logic [5:0]  IDX_AUX_ONE  = 6'h07;
  localparam logic [5:0]  IDX_AUX_TWO  = 6'h08;
  localparam logic [5:0]  IDX_TEMP_ONE = 6'h09;
  localparam logic [5:0]  IDX_TEMP_TWO = 6'h0A;
  localparam logic [5:0]  IDX_LAST     = 6'h3F;

  // ==========================================================================
  // control register fields
  localparam int          CTRL_RSVD_BIT = 15;
  localparam int          CTRL_STOP_BIT = 14;

  // ==========================================================================
  // result format and reset values
  localparam int          RES_W        = 12;
  localparam logic [15:0] RESULT_RST   = 16'h0000;
  localparam logic [15:0] PAST_END_WORD = 16'hFFFF;
  localparam logic [15:0] RSVD_WORD    = 16'h0000;

  // ==========================================================================
  // converter channel codes
  localparam int          CH_NUM       = 5;
  localparam logic [2:0]  CH_BATTERY   = 3'h0;
  localparam logic [2:0]  CH_AUX_ONE   = 3'h1;
  localparam logic [2:0]  CH_AUX_TWO   = 3'h2;
  localparam logic [2:0]  CH_TEMP_ONE  = 3'h3;
  localparam logic [2:0]  CH_TEMP_TWO  = 3'h4;

  // ==========================================================================
  // pin synchroniser depth
  localparam int          SYNC_STAGES  = 3;

  // serial engine states
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_READ, ST_WRITE, ST_SKIP
  } aarr_state_t;

endpackage

// ---- src/aarr_pin_sync.sv ----
// aarr_pin_sync: three-stage synchroniser with agreement filter for pin inputs
// assumes pins are asynchronous to CLK; output moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module aarr_pin_sync #(
  parameter int          W       = 1,
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  // clock, reset, enable
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // pins in, filtered level out
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  import aarr_pkg::*;

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ==========================================================================
  // stage chain; s1 feeds only s2 to keep metastability contained
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= RST_VAL[W-1:0];
      s2 <= RST_VAL[W-1:0];
      s3 <= RST_VAL[W-1:0];
    end else if (ce) begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // per bit: accept a change only when the last two stages agree
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          level[g] <= RST_VAL[g];
        end else if (ce && (s2[g] == s3[g])) begin
          level[g] <= s3[g];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ---- bench/aarr_host_model.sv ----
// aarr_host_model: host processor side of the command word serial port
// assumes mode 0 and a CLK fast enough to time SCLK phases of 8 cycles
`timescale 1ns/1ps
`default_nettype none
module aarr_host_model (
  // timing reference
  input  wire logic clk,
  // serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  // ==========================================================================
  // captured read words and output enable sighting
  logic [15:0] rd_buf [0:7];
  logic        oe_seen;

  // idle pins: deselected, clock low
  initial begin
    sclk    = 1'b0;
    cs_n    = 1'b1;
    mosi    = 1'b0;
    oe_seen = 1'b0;
  end

  // one word, MSB first; 8 CLK phases leave room for the pin filter delay
  task automatic word(input logic [15:0] wd, output logic [15:0] got);
    for (int i = 15; i >= 0; i--) begin
      sclk <= 1'b0;
      mosi <= wd[i];
      repeat (8) @(posedge clk);
      sclk   <= 1'b1;
      // no pull on the line: an undriven bit shows inverted so a late enable is caught
      got[i] = (miso_oe === 1'b1) ? miso : ~miso;
      if (miso_oe === 1'b1) oe_seen = 1'b1;
      repeat (8) @(posedge clk);
    end
  endtask

  // whole frame: command word, then n data words carrying wd, top bit cleared for a control register write
  task automatic frame(input logic [15:0] cmd, input int n, input logic [15:0] wd);
    logic [15:0] junk;
    logic [15:0] wd_eff;
    wd_eff  = (cmd[15:5] == 11'h040) ? {1'b0, wd[14:0]} : wd;
    oe_seen = 1'b0;
    cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    word(cmd, junk);
    for (int k = 0; k < n; k++) word(wd_eff, rd_buf[k]);
    sclk <= 1'b0;
    repeat (8) @(posedge clk);
    cs_n <= 1'b1;
    mosi <= ~mosi;  // no stale level on the line once deselected
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// testbench: directed scenarios for the converter result register block
// assumes aarr_host_model plays the host and the bench plays the converter core
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import aarr_pkg::*;
  // ==========================================================================
  // stimulus and observed signals
  logic        clk, sys_rst, ce, conv_start, conv_done;
  logic [2:0]  conv_chan;
  logic [11:0] conv_data;
  logic        sclk, cs_n, mosi, miso, miso_oe, busy, abort, pdown;
  int          err_count, num_checks, abort_cnt, base;

  // 50 MHz clock
  always #10 clk = ~clk;

  aarr_top uut (
    .CLK(clk), .SYS_RST(sys_rst), .CE(ce),
    .SPI_SCLK(sclk), .SPI_CS_N(cs_n), .SPI_MOSI(mosi),
    .SPI_MISO(miso), .SPI_MISO_OE(miso_oe),
    .CONV_START(conv_start), .CONV_DONE(conv_done), .CONV_CHAN(conv_chan),
    .CONV_DATA(conv_data), .CONV_BUSY(busy), .CONV_ABORT(abort),
    .CONV_POWER_DOWN(pdown)
  );

  aarr_host_model host (
    .clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe)
  );

  // count stop pulses so a scenario can tell one from none or two
  always @(posedge clk) begin
    if (abort === 1'b1) abort_cnt <= abort_cnt + 1;
  end

  // ==========================================================================
  // helpers
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [3:0] pg, input logic [5:0] idx, input int n);
    host.frame({1'b1, pg, idx, 5'h00}, n, 16'h0000);
  endtask

  task automatic wr(input logic [3:0] pg, input logic [5:0] idx, input logic [15:0] d);
    host.frame({1'b0, pg, idx, 5'h00}, 1, d);
  endtask

  // start pulse; busy follows one CLK later unless powered down or the clock enable is low
  task automatic conv_go(input logic exp_busy);
    conv_start <= 1'b1;
    @(posedge clk);
    conv_start <= 1'b0;
    @(posedge clk);
    check("busy after start", {15'h0000, exp_busy}, {15'h0000, busy});
  endtask

  // done pulse with its channel and value; data line scrambled afterwards
  task automatic conv_end(input logic [2:0] ch, input logic [11:0] d);
    conv_done <= 1'b1;
    conv_chan <= ch;
    conv_data <= d;
    @(posedge clk);
    conv_done <= 1'b0;
    conv_data <= ~d;
    @(posedge clk);
    check("busy after done", 16'h0000, {15'h0000, busy});
  endtask

  function automatic logic [11:0] val(input logic [2:0] ch);
    return {1'b1, ch, 8'h5A};
  endfunction

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    rd(PAGE_DATA, IDX_BATTERY, 6);
    for (int k = 0; k < 6; k++) check("result at reset", RESULT_RST, host.rd_buf[k]);
    rd(PAGE_AUXCTL, IDX_CONV_CTRL, 1);
    check("control at reset", 16'h4000, host.rd_buf[0]);
    check("power down at reset", 16'h0000, {15'h0000, pdown});
    // a start while the clock enable is low must not be taken
    ce <= 1'b0;
    conv_go(1'b0);
    ce <= 1'b1;
    $display("test reset done");
  endtask

  task automatic t_store();
    logic [15:0] exp [0:5];
    for (int c = 0; c < 5; c++) begin
      conv_go(1'b1);
      conv_end(c[2:0], val(c[2:0]));
    end
    conv_go(1'b1);
    conv_end(3'h5, 12'h123);
    exp = '{{4'h0, val(CH_BATTERY)}, 16'h0000, {4'h0, val(CH_AUX_ONE)},
            {4'h0, val(CH_AUX_TWO)}, {4'h0, val(CH_TEMP_ONE)}, {4'h0, val(CH_TEMP_TWO)}};
    rd(PAGE_DATA, IDX_BATTERY, 6);
    for (int k = 0; k < 6; k++) check("stored result", exp[k], host.rd_buf[k]);
    $display("test store done");
  endtask

  task automatic t_busy_read();
    conv_go(1'b1);
    rd(PAGE_AUXCTL, IDX_CONV_CTRL, 1);
    check("control while busy", 16'h0000, host.rd_buf[0]);
    check("busy held", 16'h0001, {15'h0000, busy});
    conv_end(CH_TEMP_ONE, 12'hFFF);
    rd(PAGE_DATA, IDX_TEMP_ONE, 1);
    check("full scale result", 16'h0FFF, host.rd_buf[0]);
    rd(PAGE_AUXCTL, IDX_CONV_CTRL, 1);
    check("control idle read", 16'h4000, host.rd_buf[0]);
    $display("test busy read done");
  endtask

  task automatic t_host_write();
    wr(PAGE_DATA, IDX_AUX_ONE, 16'hFFFF);
    rd(PAGE_DATA, IDX_AUX_ONE, 1);
    check("result after host write", {4'h0, val(CH_AUX_ONE)}, host.rd_buf[0]);
    $display("test host write done");
  endtask

  task automatic t_stop();
    conv_go(1'b1);
    base = abort_cnt;
    wr(PAGE_AUXCTL, IDX_CONV_CTRL, 16'h4000);
    check("stop pulses", 16'h0001, 16'(abort_cnt - base));
    check("busy after stop", 16'h0000, {15'h0000, busy});
    check("power down set", 16'h0001, {15'h0000, pdown});
    conv_go(1'b0);
    rd(PAGE_AUXCTL, IDX_CONV_CTRL, 1);
    check("control after stop", 16'h4000, host.rd_buf[0]);
    wr(PAGE_AUXCTL, IDX_CONV_CTRL, 16'h0000);
    check("power down clear", 16'h0000, {15'h0000, pdown});
    conv_go(1'b1);
    conv_end(CH_BATTERY, 12'h001);
    $display("test stop done");
  endtask

  task automatic t_page_end();
    rd(PAGE_DATA, IDX_LAST - 6'h01, 4);
    check("index 3E", 16'h0000, host.rd_buf[0]);
    check("index 3F", 16'h0000, host.rd_buf[1]);
    check("past end 1", PAST_END_WORD, host.rd_buf[2]);
    check("past end 2", PAST_END_WORD, host.rd_buf[3]);
    check("enable in read", 16'h0001, {15'h0000, host.oe_seen});
    host.frame(16'h80A1, 1, 16'h0000);
    // the line stays undriven, so the host sees it inverted
    check("bad pad data", 16'hFFFF, host.rd_buf[0]);
    check("bad pad enable", 16'h0000, {15'h0000, host.oe_seen});
    $display("test page end done");
  endtask

  // a reset in mid-run must drop stored results and the stop state
  task automatic t_mid_reset();
    wr(PAGE_AUXCTL, IDX_CONV_CTRL, 16'h4000);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk);
    check("power down after reset", 16'h0000, {15'h0000, pdown});
    rd(PAGE_DATA, IDX_BATTERY, 6);
    for (int k = 0; k < 6; k++) check("result after reset", RESULT_RST, host.rd_buf[k]);
    rd(PAGE_AUXCTL, IDX_CONV_CTRL, 1);
    check("control after reset", 16'h4000, host.rd_buf[0]);
    $display("test mid reset done");
  endtask

  // ==========================================================================
  // closing report
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    $display("Error watchdog expected finish seen timeout");
    complete_run();
  end

  // main sequence
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    conv_start = 1'b0;
    conv_done = 1'b0;
    conv_chan = 3'h0;
    conv_data = 12'h000;
    err_count = 0;
    num_checks = 0;
    abort_cnt = 0;
    ce = 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk);
    t_reset();
    t_store();
    t_busy_read();
    t_host_write();
    t_stop();
    t_page_end();
    t_mid_reset();
    complete_run();
  end
endmodule
`default_nettype wire
